// >>> inc/ptl_pkg.sv
/*
 * holds the shared constants of the pressure/temperature pwm frame link:
 * clock rate, tick rate, frame block lengths, pulse coding and sample layout.
 * assumes a single 20 MHz clock; all times are counted in 100 ns ticks.
 */
`default_nettype none

package ptl_pkg;

   // ****************************************************************
   // clock and tick timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 50;                           // 20 MHz
   localparam int unsigned TICK_NS       = 100;                          // resolution of 0.1 us
   localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;      // clocks per tick
   localparam int unsigned TICKS_PER_US  = 1000 / TICK_NS;

   // ****************************************************************
   // frame layout: diagnostic block then two value blocks
   // ****************************************************************
   localparam int unsigned FRAME_US      = 9216;
   localparam int unsigned DIAG_BLK_US   = 1024;
   localparam int unsigned VAL_BLK_US    = 4096;
   localparam int unsigned DIAG_BLK_TICKS = DIAG_BLK_US * TICKS_PER_US;
   localparam int unsigned VAL_BLK_TICKS  = VAL_BLK_US * TICKS_PER_US;

   // ****************************************************************
   // diagnostic pulse widths in us
   // ****************************************************************
   localparam int unsigned DIAG_OK_US    = 256;
   localparam int unsigned DIAG_PRES_US  = 384;
   localparam int unsigned DIAG_TEMP_US  = 512;
   localparam int unsigned DIAG_HW_US    = 640;

   // ****************************************************************
   // value coding: width = slope * value + offset for temperature, slope * value - offset for pressure
   // ****************************************************************
   localparam int          TEMP_SLOPE_TICKS = 192;   // 19.2 us per degree C
   localparam int          TEMP_OFFS_US     = 896;
   localparam int          TEMP_MIN_C       = -40;
   localparam int          TEMP_MAX_C       = 160;
   localparam int          PRES_SLOPE_TICKS = 384;   // 38.4 us per 0.1 bar
   localparam int          PRES_OFFS_US     = 64;
   localparam int          PRES_MIN_DBAR    = 5;     // 0.5 bar
   localparam int          PRES_MAX_DBAR    = 105;   // 10.5 bar

   // ****************************************************************
   // sample word layout
   // ****************************************************************
   localparam int unsigned TEMP_W        = 9;        // signed degrees C
   localparam int unsigned PRES_W        = 7;        // units of 0.1 bar
   localparam int unsigned DIAG_W        = 2;
   localparam int unsigned SMP_W         = DIAG_W + TEMP_W + PRES_W;
   localparam int unsigned WID_W         = 16;       // pulse and block counters
   localparam int unsigned FIFO_DEPTH    = 16;

   // diagnostic state carried in the sample word
   typedef enum logic [1:0] {
      DIAG_OK   = 2'h0,
      DIAG_PRES = 2'h1,
      DIAG_TEMP = 2'h2,
      DIAG_HW   = 2'h3
   } ptl_diag_type;

   // frame sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_DIAG  = 5'h02,
      ST_TEMP  = 5'h04,
      ST_PRES  = 5'h08,
      ST_FAULT = 5'h10
   } ptl_state_type;

endpackage

`default_nettype wire

// >>> design/ptl_fifo.sv
/*
 * holds a synchronous valid/ready fifo with width and depth parameters.
 * assumes one clock and a synchronous active-high reset; depth is a power of two.
 */
`timescale 1ns/1ps
`default_nettype none

module ptl_fifo #(
   parameter int unsigned WIDTH = 18,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   // fill side
   input  wire logic             i_wr_valid,
   output logic                  o_wr_ready,
   input  wire logic [WIDTH-1:0] i_wr_data,
   // drain side
   output logic                  o_rd_valid,
   input  wire logic             i_rd_ready,
   output logic      [WIDTH-1:0] o_rd_data
);

   localparam int unsigned AW = $clog2(DEPTH);

   // ****************************************************************
   // storage and pointers
   // ****************************************************************
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wr_ptr_ff;
   logic [AW:0]      rd_ptr_ff;
   logic             do_wr;
   logic             do_rd;

   // extra pointer bit tells full from empty without a counter
   assign o_wr_ready = (wr_ptr_ff[AW] == rd_ptr_ff[AW]) || (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
   assign o_rd_valid = (wr_ptr_ff != rd_ptr_ff);
   assign o_rd_data  = mem_ff[rd_ptr_ff[AW-1:0]];
   assign do_wr      = i_wr_valid && o_wr_ready;
   assign do_rd      = o_rd_valid && i_rd_ready;

   // storage write, no reset needed on data
   always_ff @(posedge i_mclk)
   begin
      if (do_wr)
      begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= i_wr_data;
      end
   end

   // pointer update
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (do_rd)
         begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// >>> design/ptl_frame_link.sv
/*
 * holds the pwm frame generator of the pressure/temperature sensor link:
 * samples queue in a fifo, each frame sends a diagnostic, a temperature and
 * a pressure pulse on one output line; an internal sequencing fault parks
 * the line high. assumes samples come from logic on i_mclk and the fault
 * flag comes from outside the clock domain.
 */
// Function
// - readings and diagnosis sent only as widths
// - frame repeats every 9216 us nominal
// - frame length within ten percent of nominal
// - sequencing fault stops frames, line held high
// - diagnostic widths 256, 384, 512 us
// - hardware failure diagnostic width 640 us
// - temperature width 19.2 per degree plus 896
// - pressure width 384 per bar minus 64
`timescale 1ns/1ps
`default_nettype none

module ptl_frame_link #(
   parameter int unsigned P_DIAG_BLK_TICKS = ptl_pkg::DIAG_BLK_TICKS,
   parameter int unsigned P_VAL_BLK_TICKS  = ptl_pkg::VAL_BLK_TICKS,
   parameter int unsigned P_FIFO_DEPTH     = ptl_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                               i_mclk,
   input  wire logic                               i_rst,
   // measurement samples
   input  wire logic                               i_smp_valid,
   output logic                                    o_smp_ready,
   input  wire logic signed [ptl_pkg::TEMP_W-1:0]  i_smp_temp,
   input  wire logic        [ptl_pkg::PRES_W-1:0]  i_smp_pres,
   input  wire logic                               i_smp_pres_fail,
   input  wire logic                               i_smp_temp_fail,
   input  wire logic                               i_smp_hw_fail,
   // internal sequencing fault, asynchronous level
   input  wire logic                               i_seq_fault,
   // link line and status
   output logic                                    o_pwm,
   output logic                                    o_frame_start,
   output logic                                    o_fault
);

   // ****************************************************************
   // width coding functions
   // ****************************************************************

   // temperature degrees to ticks, clamped to the measuring range
   function automatic logic [ptl_pkg::WID_W-1:0] temp_ticks(input logic signed [ptl_pkg::TEMP_W-1:0] t);
      int v;
      v = int'(t);
      if (v < ptl_pkg::TEMP_MIN_C)
      begin
         v = ptl_pkg::TEMP_MIN_C;
      end
      if (v > ptl_pkg::TEMP_MAX_C)
      begin
         v = ptl_pkg::TEMP_MAX_C;
      end
      v = ptl_pkg::TEMP_SLOPE_TICKS * v + ptl_pkg::TEMP_OFFS_US * int'(ptl_pkg::TICKS_PER_US);
      return v[ptl_pkg::WID_W-1:0];
   endfunction

   // pressure in 0.1 bar to ticks, clamped to the measuring range
   function automatic logic [ptl_pkg::WID_W-1:0] pres_ticks(input logic [ptl_pkg::PRES_W-1:0] p);
      int v;
      v = int'(p);
      if (v < ptl_pkg::PRES_MIN_DBAR)
      begin
         v = ptl_pkg::PRES_MIN_DBAR;
      end
      if (v > ptl_pkg::PRES_MAX_DBAR)
      begin
         v = ptl_pkg::PRES_MAX_DBAR;
      end
      v = ptl_pkg::PRES_SLOPE_TICKS * v - ptl_pkg::PRES_OFFS_US * int'(ptl_pkg::TICKS_PER_US);
      return v[ptl_pkg::WID_W-1:0];
   endfunction

   // diagnostic code to ticks
   function automatic logic [ptl_pkg::WID_W-1:0] diag_ticks(input ptl_pkg::ptl_diag_type d);
      int unsigned us;
      unique case (d)
         ptl_pkg::DIAG_OK:   us = ptl_pkg::DIAG_OK_US;
         ptl_pkg::DIAG_PRES: us = ptl_pkg::DIAG_PRES_US;
         ptl_pkg::DIAG_TEMP: us = ptl_pkg::DIAG_TEMP_US;
         ptl_pkg::DIAG_HW:   us = ptl_pkg::DIAG_HW_US;
      endcase
      us = us * ptl_pkg::TICKS_PER_US;
      return us[ptl_pkg::WID_W-1:0];
   endfunction

   localparam logic [ptl_pkg::WID_W-1:0] DIAG_LAST = ptl_pkg::WID_W'(P_DIAG_BLK_TICKS - 1);
   localparam logic [ptl_pkg::WID_W-1:0] VAL_LAST  = ptl_pkg::WID_W'(P_VAL_BLK_TICKS - 1);
   localparam logic [1:0]                TICK_LAST = 2'(ptl_pkg::TICK_CYC - 1);

   // ****************************************************************
   // sample fifo
   // ****************************************************************
   ptl_pkg::ptl_diag_type           smp_diag;
   logic [ptl_pkg::SMP_W-1:0]       smp_word;
   logic [ptl_pkg::SMP_W-1:0]       q_word;
   logic                            q_valid;
   logic                            q_ready;

   // worst failure wins the single diagnostic slot
   always_comb
   begin
      if (i_smp_hw_fail)
      begin
         smp_diag = ptl_pkg::DIAG_HW;
      end
      else if (i_smp_temp_fail)
      begin
         smp_diag = ptl_pkg::DIAG_TEMP;
      end
      else if (i_smp_pres_fail)
      begin
         smp_diag = ptl_pkg::DIAG_PRES;
      end
      else
      begin
         smp_diag = ptl_pkg::DIAG_OK;
      end
   end

   assign smp_word = {smp_diag, i_smp_temp, i_smp_pres};

   ptl_fifo #(
      .WIDTH (ptl_pkg::SMP_W),
      .DEPTH (P_FIFO_DEPTH)
   ) u_fifo (
      .i_mclk     (i_mclk),
      .i_rst      (i_rst),
      .i_wr_valid (i_smp_valid),
      .o_wr_ready (o_smp_ready),
      .i_wr_data  (smp_word),
      .o_rd_valid (q_valid),
      .i_rd_ready (q_ready),
      .o_rd_data  (q_word)
   );

   // ****************************************************************
   // fault synchroniser and tick divider
   // ****************************************************************
   logic       fault_m_ff;
   logic       fault_s_ff;
   logic [1:0] tick_cnt_ff;
   logic       tick;

   // two flops before the fault level is looked at
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         fault_m_ff <= 1'b0;
         fault_s_ff <= 1'b0;
      end
      else
      begin
         fault_m_ff <= i_seq_fault;
         fault_s_ff <= fault_m_ff;
      end
   end

   // 100 ns tick gives 0.1 us width resolution, enough for the 19.2 us slope
   always_ff @(posedge i_mclk)
   begin
      if (i_rst || tick)
      begin
         tick_cnt_ff <= '0;
      end
      else
      begin
         tick_cnt_ff <= tick_cnt_ff + 2'h1;
      end
   end

   assign tick = (tick_cnt_ff == TICK_LAST);

   // ****************************************************************
   // frame sequencer
   // ****************************************************************
   ptl_pkg::ptl_state_type          state_ff;
   ptl_pkg::ptl_state_type          nxt_state;
   logic [ptl_pkg::WID_W-1:0]       pos_ff;
   logic [ptl_pkg::WID_W-1:0]       diag_w_ff;
   logic [ptl_pkg::WID_W-1:0]       temp_w_ff;
   logic [ptl_pkg::WID_W-1:0]       pres_w_ff;
   logic [ptl_pkg::WID_W-1:0]       cur_w;
   logic [ptl_pkg::WID_W-1:0]       cur_last;
   logic                            blk_end;
   logic                            frame_edge;
   logic                            nxt_pwm;

   // width and length of the block being sent
   always_comb
   begin
      cur_w    = '0;
      cur_last = VAL_LAST;
      unique case (state_ff)
         ptl_pkg::ST_DIAG:
         begin
            cur_w    = diag_w_ff;
            cur_last = DIAG_LAST;
         end
         ptl_pkg::ST_TEMP:  cur_w = temp_w_ff;
         ptl_pkg::ST_PRES:  cur_w = pres_w_ff;
         ptl_pkg::ST_IDLE:  cur_w = '0;
         ptl_pkg::ST_FAULT: cur_w = '0;
      endcase
   end

   assign blk_end    = tick && (pos_ff == cur_last);
   // a new frame begins after the pressure block, or from idle
   assign frame_edge = tick && ((state_ff == ptl_pkg::ST_IDLE) ||
                                ((state_ff == ptl_pkg::ST_PRES) && (pos_ff == VAL_LAST)));
   // a queued sample is taken only at a frame boundary; otherwise the fifo backs up
   assign q_ready    = frame_edge && !fault_s_ff;

   // next state: fixed field order, fault overrides everything
   always_comb
   begin
      nxt_state = state_ff;
      if (fault_s_ff)
      begin
         nxt_state = ptl_pkg::ST_FAULT;
      end
      else
      begin
         unique case (state_ff)
            ptl_pkg::ST_IDLE:  if (tick && q_valid) nxt_state = ptl_pkg::ST_DIAG;
            ptl_pkg::ST_DIAG:  if (blk_end) nxt_state = ptl_pkg::ST_TEMP;
            ptl_pkg::ST_TEMP:  if (blk_end) nxt_state = ptl_pkg::ST_PRES;
            ptl_pkg::ST_PRES:  if (blk_end) nxt_state = ptl_pkg::ST_DIAG;
            ptl_pkg::ST_FAULT: nxt_state = ptl_pkg::ST_FAULT;
            default:           nxt_state = ptl_pkg::ST_IDLE;
         endcase
      end
   end

   // state register; only reset leaves the fault state
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         state_ff <= ptl_pkg::ST_IDLE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // position inside the block; exact block lengths keep frame at nominal
   always_ff @(posedge i_mclk)
   begin
      if (i_rst || (state_ff == ptl_pkg::ST_IDLE) || (state_ff == ptl_pkg::ST_FAULT) || blk_end)
      begin
         pos_ff <= '0;
      end
      else if (tick)
      begin
         pos_ff <= pos_ff + 1'b1;
      end
   end

   // widths latched per frame; with an empty fifo the last sample repeats
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         diag_w_ff <= '0;
         temp_w_ff <= '0;
         pres_w_ff <= '0;
      end
      else if (q_ready && q_valid)
      begin
         diag_w_ff <= diag_ticks(ptl_pkg::ptl_diag_type'(q_word[ptl_pkg::SMP_W-1 -: ptl_pkg::DIAG_W]));
         temp_w_ff <= temp_ticks(q_word[ptl_pkg::PRES_W +: ptl_pkg::TEMP_W]);
         pres_w_ff <= pres_ticks(q_word[ptl_pkg::PRES_W-1:0]);
      end
   end

   // ****************************************************************
   // line driver
   // ****************************************************************

   // each block starts high for its coded width, then low
   assign nxt_pwm = (state_ff == ptl_pkg::ST_FAULT) || fault_s_ff ||
                    ((state_ff != ptl_pkg::ST_IDLE) && (pos_ff < cur_w));

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_pwm         <= 1'b0;
         o_frame_start <= 1'b0;
         o_fault       <= 1'b0;
      end
      else
      begin
         o_pwm         <= nxt_pwm;
         o_frame_start <= frame_edge && q_valid && !fault_s_ff;
         o_fault       <= (state_ff == ptl_pkg::ST_FAULT) || fault_s_ff; // rises with the parked line
      end
   end

endmodule

`default_nettype wire

// >>> test/ptl_frame_link_chk.sv
/*
 * holds the port checker of the pwm frame link, bound to the top module.
 * assumes one clock domain and the top module's block-length parameters.
 */
`timescale 1ns/1ps
`default_nettype none

module ptl_frame_link_chk #(
   parameter int unsigned P_DIAG_BLK_TICKS = ptl_pkg::DIAG_BLK_TICKS,
   parameter int unsigned P_VAL_BLK_TICKS  = ptl_pkg::VAL_BLK_TICKS,
   parameter int unsigned P_FIFO_DEPTH     = ptl_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                              i_mclk,
   input  wire logic                              i_rst,
   // sample side
   input  wire logic                              i_smp_valid,
   input  wire logic                              o_smp_ready,
   input  wire logic signed [ptl_pkg::TEMP_W-1:0] i_smp_temp,
   input  wire logic        [ptl_pkg::PRES_W-1:0] i_smp_pres,
   input  wire logic                              i_smp_pres_fail,
   input  wire logic                              i_smp_temp_fail,
   input  wire logic                              i_smp_hw_fail,
   input  wire logic                              i_seq_fault,
   // line side
   input  wire logic                              o_pwm,
   input  wire logic                              o_frame_start,
   input  wire logic                              o_fault
);
   // ****************************************************************
   // helper counters
   // ****************************************************************
   localparam int unsigned FRAME_CYC = (P_DIAG_BLK_TICKS + 2 * P_VAL_BLK_TICKS) * ptl_pkg::TICK_CYC;
   localparam int unsigned HI_MAX    = (ptl_pkg::TEMP_SLOPE_TICKS * ptl_pkg::TEMP_MAX_C
                                        + ptl_pkg::TEMP_OFFS_US * ptl_pkg::TICKS_PER_US) * ptl_pkg::TICK_CYC;
   logic [31:0] gap_ff;
   logic [31:0] hi_ff;
   logic        seen_ff;
   logic        taken_ff;

   // distance between frame starts; seen_ff guards the first frame
   always_ff @(posedge i_mclk)
   begin
      gap_ff  <= (i_rst || o_frame_start) ? 32'h0 : gap_ff + 32'h1;
      seen_ff <= !i_rst && (seen_ff || o_frame_start);
   end

   // length of the current high run of the line
   always_ff @(posedge i_mclk)
      hi_ff <= (i_rst || !o_pwm) ? 32'h0 : hi_ff + 32'h1;

   // a sample has entered since reset
   always_ff @(posedge i_mclk)
      taken_ff <= !i_rst && (taken_ff || (i_smp_valid && o_smp_ready));

   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   sequence s_fault_held;
      i_seq_fault [*6];
   endsequence
   sequence s_line_rise;
      $rose(o_pwm);
   endsequence

   AST_RESET_QUIET: assert property ($fell(i_rst) |-> !o_pwm && !o_fault && o_smp_ready)
      else $error("outputs not quiet after reset");
   AST_FAULT_ENTRY: assert property (s_fault_held |-> o_fault)
      else $error("fault input held but no fault");
   AST_FAULT_STICKY: assert property (o_fault |=> o_fault)
      else $error("fault flag dropped");
   AST_FAULT_LINE_HIGH: assert property (o_fault [*2] |-> o_pwm && !o_frame_start)
      else $error("line not parked high in fault");
   AST_FRAME_PERIOD: assert property (o_frame_start && seen_ff |-> gap_ff == FRAME_CYC - 1)
      else $error("frame period wrong");
   AST_START_THEN_PULSE: assert property (o_frame_start |-> ##[0:2] s_line_rise)
      else $error("frame start without diagnostic pulse");
   AST_HIGH_BOUNDED: assert property (!o_fault |-> hi_ff <= HI_MAX)
      else $error("pulse longer than widest code");
   AST_IDLE_LOW: assert property (!taken_ff && !o_fault |-> !o_pwm && !o_frame_start)
      else $error("line active before first sample");
   AST_START_ONE_CYCLE: assert property (o_frame_start |=> !o_frame_start)
      else $error("frame start longer than one cycle");
endmodule

bind ptl_frame_link ptl_frame_link_chk #(
   .P_DIAG_BLK_TICKS(P_DIAG_BLK_TICKS),
   .P_VAL_BLK_TICKS (P_VAL_BLK_TICKS),
   .P_FIFO_DEPTH    (P_FIFO_DEPTH)
) u_chk (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready),
   .i_smp_temp(i_smp_temp), .i_smp_pres(i_smp_pres), .i_smp_pres_fail(i_smp_pres_fail),
   .i_smp_temp_fail(i_smp_temp_fail), .i_smp_hw_fail(i_smp_hw_fail), .i_seq_fault(i_seq_fault),
   .o_pwm(o_pwm), .o_frame_start(o_frame_start), .o_fault(o_fault)
);

`default_nettype wire

// >>> test/ptl_ecu_model.sv
/*
 * holds a behavioural control unit that times the pulses of the pwm line.
 * assumes the line starts low after reset and the first pulse is diagnostic.
 */
`timescale 1ns/1ps
`default_nettype none

module ptl_ecu_model #(
   parameter int unsigned P_HIGH_LIMIT = 13000
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   // sensor line
   input  wire logic        i_line,
   // decoded widths in clocks
   output logic      [31:0] o_diag_w,
   output logic      [31:0] o_temp_w,
   output logic      [31:0] o_pres_w,
   output logic      [31:0] o_period,
   output logic      [31:0] o_frames,
   output logic             o_fault_seen
);
   logic [31:0] hi_ff;
   logic [31:0] since_ff;
   logic [1:0]  idx_ff;
   logic        line_ff;

   // capture runs every clock, twice as fine as the pulse resolution
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         {hi_ff, since_ff, o_period, o_frames} <= '0;
         {o_diag_w, o_temp_w, o_pres_w} <= '0;
         {idx_ff, line_ff, o_fault_seen} <= '0;
      end
      else
      begin
         line_ff  <= i_line;
         since_ff <= since_ff + 32'h1;
         hi_ff    <= i_line ? hi_ff + 32'h1 : 32'h0; // 32 bits cover 128..3968 us widely
         if (i_line && !line_ff && idx_ff == 2'h0)
         begin
            o_period <= since_ff;
            since_ff <= 32'h1;
         end
         // fields known by order only, so any frame length is accepted
         if (!i_line && line_ff)
         begin
            case (idx_ff)
               2'h0:    o_diag_w <= hi_ff;
               2'h1:    o_temp_w <= hi_ff;
               default: o_pres_w <= hi_ff;
            endcase
            idx_ff <= (idx_ff == 2'h2) ? 2'h0 : idx_ff + 2'h1;
            if (idx_ff == 2'h2)
               o_frames <= o_frames + 32'h1;
         end
         // a high level longer than any block means the sensor gave up
         if (hi_ff >= P_HIGH_LIMIT)
            o_fault_seen <= 1'b1;
      end
   end
endmodule

`default_nettype wire

// >>> test/ptl_frame_link_tb.sv
/*
 * holds the self-checking bench of the pwm frame link with shortened blocks.
 * assumes the checker is bound by its own file and the control unit model.
 */
`timescale 1ns/1ps
`default_nettype none

module ptl_frame_link_tb;
   // ****************************************************************
   // setup: value blocks cut to 200 us, so only small values fit
   // ****************************************************************
   localparam int unsigned DIAG_T    = 6500;
   localparam int unsigned VAL_T     = 2000;
   localparam int unsigned UC        = ptl_pkg::TICKS_PER_US * ptl_pkg::TICK_CYC;
   localparam int unsigned FRAME_CYC = (DIAG_T + 2 * VAL_T) * ptl_pkg::TICK_CYC;
   logic               mclk, rst = 1'b1, valid = 1'b0, pf = 1'b0, tf = 1'b0, hw = 1'b0, seq_fault = 1'b0;
   logic signed [8:0]  temp = '0;
   logic        [6:0]  pres = '0;
   logic               ready, pwm, fstart, fault, fault_seen;
   logic        [31:0] diag_w, temp_w, pres_w, period, frames;
   int                 fails = 0;
   int                 cmp_count = 0;
   int                 tv [4] = '{-40, -37, -50, -38};
   int                 pv [4] = '{5, 6, 2, 6};
   // expected inputs after clamping to the measuring range
   int                 te [4] = '{-40, -37, -40, -38};
   int                 pe [4] = '{5, 6, 5, 6};
   logic        [2:0]  fv [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
   int                 dv [4] = '{ptl_pkg::DIAG_OK_US, ptl_pkg::DIAG_PRES_US, ptl_pkg::DIAG_TEMP_US, ptl_pkg::DIAG_HW_US};

   ptl_frame_link #(.P_DIAG_BLK_TICKS(DIAG_T), .P_VAL_BLK_TICKS(VAL_T)) u_dut (
      .i_mclk(mclk), .i_rst(rst), .i_smp_valid(valid), .o_smp_ready(ready), .i_smp_temp(temp),
      .i_smp_pres(pres), .i_smp_pres_fail(pf), .i_smp_temp_fail(tf), .i_smp_hw_fail(hw),
      .i_seq_fault(seq_fault), .o_pwm(pwm), .o_frame_start(fstart), .o_fault(fault));
   ptl_ecu_model #(.P_HIGH_LIMIT(DIAG_T * ptl_pkg::TICK_CYC)) u_ecu (
      .i_mclk(mclk), .i_rst(rst), .i_line(pwm), .o_diag_w(diag_w), .o_temp_w(temp_w),
      .o_pres_w(pres_w), .o_period(period), .o_frames(frames), .o_fault_seen(fault_seen));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %0d seen %0d", name, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // offer one word, held until ready is seen before the taking edge
   task automatic push(input int t, input int p, input logic [2:0] f);
      @(posedge mclk);
      valid <= 1'b1;
      temp  <= 9'(t);
      pres  <= 7'(p);
      {hw, tf, pf} <= f;
      @(negedge mclk);
      while (ready !== 1'b1)
         @(negedge mclk);
      @(posedge mclk);
      valid <= 1'b0;
   endtask

   task automatic wait_frames(input int n);
      int k;
      k = 0;
      while (frames < n && k < 2 * FRAME_CYC)
      begin
         @(negedge mclk);
         k++;
      end
      chk("frame count", frames, n);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_idle;
      repeat (200) @(negedge mclk);
      chk("idle line", pwm, 1'b0);
      chk("ready after reset", ready, 1'b1);
   endtask

   // four frames, one per diagnostic code; later flags win by priority; frame three clamps
   task automatic t_frames;
      for (int i = 0; i < 4; i++)
         push(tv[i], pv[i], fv[i]);
      for (int i = 0; i < 4; i++)
      begin
         wait_frames(i + 1);
         chk("diag width", diag_w, dv[i] * UC);
         chk("temp width", temp_w, (192 * te[i] + 896 * 10) * ptl_pkg::TICK_CYC);
         chk("pres width", pres_w, (384 * pe[i] - 64 * 10) * ptl_pkg::TICK_CYC);
         if (i > 0)
            chk("frame period", period, FRAME_CYC);
      end
   endtask

   // a short fault pulse must park the line high for good
   task automatic t_fault;
      logic [31:0] f0;
      @(posedge mclk);
      seq_fault <= 1'b1;
      repeat (8) @(posedge mclk);
      seq_fault <= 1'b0;
      @(negedge mclk);
      chk("fault flag", fault, 1'b1);
      f0 = frames;
      repeat (DIAG_T * ptl_pkg::TICK_CYC + 1000) @(negedge mclk);
      chk("line parked", pwm, 1'b1);
      chk("fault detected", fault_seen, 1'b1);
      chk("frames stopped", frames, f0);
   endtask

   // second reset clears the fault, then the queue is filled to refusal
   task automatic t_fill;
      int n;
      n = 0;
      @(posedge mclk);
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk("fault cleared", fault, 1'b0);
      @(posedge mclk);
      valid <= 1'b1;
      repeat (24)
      begin
         @(negedge mclk);
         if (ready === 1'b1)
            n++;
         @(posedge mclk);
      end
      @(negedge mclk);
      chk("ready when full", ready, 1'b0);
      chk("words taken", n, ptl_pkg::FIFO_DEPTH + 1);
      @(posedge mclk);
      valid <= 1'b0;
   endtask

   // ****************************************************************
   // clock, sequence and watchdog
   // ****************************************************************
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial
   begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_idle;
      t_frames;
      t_fault;
      t_fill;
      close_out;
   end

   // four frames, the fault wait and some slack
   initial
   begin
      repeat (4 * FRAME_CYC + 30000) @(posedge mclk);
      fails++;
      close_out;
   end
endmodule

`default_nettype wire
